/* pci_config_header_regs.sv */
`timescale 1ns/1ps
module pci_config_header_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic frame_start,
  input wire logic master_busy,
  input wire logic gnt_n,
  output logic tenure_stop,
  output logic tenure_expired,
  output logic [cfg_hdr_pkg::LINE_W-1:0] line_length_setting,
  output logic [cfg_hdr_pkg::WIN_W-1:0] window_upper_bits,
  input wire logic [31:0] mem_addr,
  output logic window_hit
);
  import cfg_hdr_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (WIN_W + WIN_LSB != 32) begin : g_bad_win
    $error("window field must end at bit 31");
  end
  if (LIMIT_W != 8 || LINE_W != 8) begin : g_bad_byte
    $error("tenure and line fields must be one byte");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic lane_on(input logic [3:0] be,
                                   input logic [1:0] lane);
    return be[lane];
  endfunction : lane_on

  function automatic logic [7:0] byte_sel(input logic en,
                                          input logic [7:0] nv,
                                          input logic [7:0] ov);
    return en ? nv : ov;
  endfunction : byte_sel

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [LIMIT_W-1:0] tenure_ff;
  logic [LINE_W-1:0] line_ff;
  logic [WIN_W-1:0] win_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic hit_ff;
  logic expired_ff;
  logic gnt_n_sync;
  tenure_if tif ();

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  wire wr = cfg_valid & cfg_write;
  wire rd = cfg_valid & ~cfg_write;
  wire sel_tl = cfg_dword == DW_TENURE_LINE;
  wire sel_win = cfg_dword == DW_WINDOW;
  wire wr_tl = wr & sel_tl;
  wire wr_win = wr & sel_win;
  wire rd_win = rd & sel_win;
  wire wr_line = wr_tl & lane_on(cfg_be, LANE_LINE);
  wire wr_tenure = wr_tl & lane_on(cfg_be, LANE_TENURE);
  wire wr_win1 = wr_win & lane_on(cfg_be, 2'h1);
  wire wr_win2 = wr_win & lane_on(cfg_be, 2'h2);
  wire wr_win3 = wr_win & lane_on(cfg_be, 2'h3);

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  // both fields writable
  wire [7:0] nxt_tenure = byte_sel(wr_tenure, cfg_wdata[15:8],
                                   tenure_ff);
  wire [7:0] nxt_line = byte_sel(wr_line, cfg_wdata[7:0], line_ff);
  wire [WIN_W-1:0] nxt_win = {
    byte_sel(wr_win3, cfg_wdata[31:24], win_ff[20:13]),
    byte_sel(wr_win2, cfg_wdata[23:16], win_ff[12:5]),
    wr_win1 ? cfg_wdata[15:11] : win_ff[4:0]
  };

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // self-test fixed
  wire [31:0] tl_word = {SELF_TEST_VAL, HEADER_LAYOUT_VAL,
                         tenure_ff, line_ff};
  wire [31:0] win_word = {win_ff, WINDOW_SIZE_VAL, PREFETCH_VAL,
                          LOCATABILITY_VAL, SPACE_VAL};
  wire [31:0] nxt_rdata = !rd ? 32'h00000000 :
                          sel_tl ? tl_word :
                          sel_win ? win_word : 32'h00000000;
  wire nxt_hit = mem_addr[31:WIN_LSB] == win_ff;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // read-only bits not stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tenure_ff <= LIMIT_RST;
      line_ff <= LINE_RST;
      win_ff <= WIN_RST;
    end else begin
      tenure_ff <= nxt_tenure;
      line_ff <= nxt_line;
      win_ff <= nxt_win;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      hit_ff <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      ack_ff <= cfg_valid;
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
      expired_ff <= tif.expired;
    end
  end

  // ------------------------------------------------------------
  // Grant pin and tenure timer
  // ------------------------------------------------------------
  pin_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_gnt_sync (
    .clk(clk),
    .rst(rst),
    .pin(gnt_n),
    .level(gnt_n_sync)
  );

  assign tif.limit = tenure_ff;
  assign tif.frame_start = frame_start;
  assign tif.busy = master_busy;
  assign tif.gnt_n_sync = gnt_n_sync;

  tenure_timer u_timer (
    .clk(clk),
    .rst(rst),
    .tif(tif.timer)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign cfg_ack = ack_ff;
  assign cfg_rdata = rdata_ff;
  assign tenure_stop = tif.stop;
  assign tenure_expired = expired_ff;
  assign line_length_setting = line_ff;
  assign window_upper_bits = win_ff;
  assign window_hit = hit_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_TENURE_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (wr_tl && cfg_be[LANE_TENURE]) |=>
      tenure_ff == $past(cfg_wdata[15:8]))
    else $error("tenure limit byte not written");

  AST_LINE_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (wr_tl && cfg_be[LANE_LINE]) |=>
      line_length_setting == $past(cfg_wdata[7:0]))
    else $error("line length byte not written");

  AST_SELFTEST_READ: assert property (
    @(posedge clk) disable iff (rst)
    (rd && sel_tl) |=> cfg_ack && cfg_rdata[31:24] == SELF_TEST_VAL)
    else $error("self-test byte not zero");

  AST_LAYOUT_READ: assert property (
    @(posedge clk) disable iff (rst)
    (rd && sel_tl) |=> cfg_ack && cfg_rdata[23:16] == HEADER_LAYOUT_VAL)
    else $error("header layout byte not zero");

  AST_WIN_ONES: assert property (
    @(posedge clk) disable iff (rst)
    (wr_win && cfg_be == 4'hf && cfg_wdata == 32'hffffffff)
      ##1 (rd && sel_win) |=> cfg_rdata == WIN_ONES_READ)
    else $error("all-ones window write read back wrong");

  AST_WIN_UPPER: assert property (
    @(posedge clk) disable iff (rst)
    (rd && sel_win) |=> cfg_rdata[31:WIN_LSB] == $past(win_ff))
    else $error("window upper bits read wrong");

  AST_WIN_SIZE: assert property (
    @(posedge clk) disable iff (rst)
    $past(rd_win) |-> cfg_rdata[10:4] == 7'h00)
    else $error("window size bits not zero");

  AST_WIN_PREFETCH: assert property (
    @(posedge clk) disable iff (rst)
    $past(rd_win) |-> !cfg_rdata[3])
    else $error("prefetch flag not zero");

  AST_WIN_LOCAT: assert property (
    @(posedge clk) disable iff (rst)
    $past(rd_win) |-> cfg_rdata[2:1] == 2'h0)
    else $error("locatability field not zero");

  AST_WIN_SPACE: assert property (
    @(posedge clk) disable iff (rst)
    $past(rd_win) |-> !cfg_rdata[0])
    else $error("space indicator not zero");

  AST_RESET_ZERO: assert property (
    @(posedge clk)
    $fell(rst) |-> tenure_ff == LIMIT_RST && line_ff == LINE_RST)
    else $error("tenure and line not zero after reset");

  AST_RO_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (wr_win && !cfg_be[1] && !cfg_be[2] && !cfg_be[3]) |=>
      $stable(window_upper_bits))
    else $error("low-lane window write changed base");

  AST_STOP_NEEDS_EXPIRY: assert property (
    @(posedge clk) disable iff (rst)
    $rose(tenure_stop) |-> $past(tif.expired, 1))
    else $error("stop without expired limit");

  AST_EXPIRED_FLAG: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> tenure_expired == $past(tif.expired))
    else $error("expired flag does not follow timer");

  AST_ACK_EACH: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> cfg_ack == $past(cfg_valid))
    else $error("ack not one cycle after request");

  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (rst)
    !rd |=> cfg_rdata == 32'h00000000)
    else $error("read data not zero without read");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (rst)
    (rd && !sel_tl && !sel_win) |=> cfg_rdata == 32'h00000000)
    else $error("unmapped read not zero");

  AST_HDR_RO_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (wr_tl && !cfg_be[LANE_LINE] && !cfg_be[LANE_TENURE]) |=>
      $stable(tenure_ff) && $stable(line_ff))
    else $error("header lane write changed tenure or line");

  AST_TENURE_HOLD: assert property (
    @(posedge clk) disable iff (rst)
    !wr_tenure |=> $stable(tenure_ff))
    else $error("tenure limit changed without write");

  AST_HIT_MATCH: assert property (
    @(posedge clk) disable iff (rst)
    (mem_addr[31:WIN_LSB] == win_ff) |=> window_hit)
    else $error("window hit missing");

  AST_HIT_MISS: assert property (
    @(posedge clk) disable iff (rst)
    (mem_addr[31:WIN_LSB] != win_ff) |=> !window_hit)
    else $error("window hit outside window");

  COV_ONES: cover property (@(posedge clk) disable iff (rst)
    (wr_win && cfg_be == 4'hf && cfg_wdata == 32'hffffffff)
      ##1 (rd && sel_win));
  COV_EXPIRE: cover property (@(posedge clk) disable iff (rst)
    $rose(tif.expired));
  COV_HDR_READ: cover property (@(posedge clk) disable iff (rst)
    rd && sel_tl);
  COV_HIT: cover property (@(posedge clk) disable iff (rst)
    window_hit && win_ff != WIN_RST);
endmodule : pci_config_header_regs

/* cfg_hdr_pkg.sv */
package cfg_hdr_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_TENURE_LINE = 8'h0c;
  localparam logic [7:0] OFS_HEADER = 8'h0e;
  localparam logic [7:0] OFS_WINDOW = 8'h10;
  localparam logic [5:0] DW_TENURE_LINE = OFS_TENURE_LINE[7:2];
  localparam logic [5:0] DW_WINDOW = OFS_WINDOW[7:2];
  localparam logic [1:0] LANE_LINE = OFS_TENURE_LINE[1:0];
  localparam logic [1:0] LANE_TENURE = 2'h1;
  localparam logic [1:0] LANE_LAYOUT = OFS_HEADER[1:0];
  localparam logic [1:0] LANE_SELFTEST = 2'h3;
  // ------------------------------------------------------------
  // Field widths and fixed values
  // ------------------------------------------------------------
  localparam int LIMIT_W = 8;
  localparam int LINE_W = 8;
  localparam int WIN_W = 21;
  localparam int WIN_LSB = 11;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [20:0] WIN_RST = 21'h000000;
  localparam logic [7:0] SELF_TEST_VAL = 8'h00;
  localparam logic [7:0] HEADER_LAYOUT_VAL = 8'h00;
  localparam logic [6:0] WINDOW_SIZE_VAL = 7'h00;
  localparam logic [0:0] PREFETCH_VAL = 1'h0;
  localparam logic [1:0] LOCATABILITY_VAL = 2'h0;
  localparam logic [0:0] SPACE_VAL = 1'h0;
  localparam logic [31:0] WIN_ONES_READ = 32'hfffff800;
  // ------------------------------------------------------------
  // Tenure timer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_COUNT = 2'b01,
    TS_EXPIRED = 2'b10
  } tenure_state_e;
endpackage : cfg_hdr_pkg

/* tenure_if.sv */
`timescale 1ns/1ps
interface tenure_if;
  import cfg_hdr_pkg::*;
  logic [LIMIT_W-1:0] limit;
  logic frame_start;
  logic busy;
  logic gnt_n_sync;
  logic expired;
  logic stop;
  modport regs (
    output limit,
    output frame_start,
    output busy,
    output gnt_n_sync,
    input expired,
    input stop
  );
  modport timer (
    input limit,
    input frame_start,
    input busy,
    input gnt_n_sync,
    output expired,
    output stop
  );
endinterface : tenure_if

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  initial begin
    if (W < 1) $error("pin_sync width must be at least one");
  end
  genvar i;
  // ------------------------------------------------------------
  // Three stages, change taken when stages two and three agree
  // ------------------------------------------------------------
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_ff <= RST_VAL[i];
          s2_ff <= RST_VAL[i];
          s3_ff <= RST_VAL[i];
          lvl_ff <= RST_VAL[i];
        end else begin
          s1_ff <= pin[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) lvl_ff <= s3_ff;
        end
      end
      assign level[i] = lvl_ff;
    end
  endgenerate
endmodule : pin_sync

/* tenure_timer.sv */
`timescale 1ns/1ps
module tenure_timer (
  input wire logic clk,
  input wire logic rst,
  tenure_if.timer tif
);
  import cfg_hdr_pkg::*;
  tenure_state_e state_ff;
  tenure_state_e nxt_state;
  logic [LIMIT_W-1:0] count_ff;
  logic [LIMIT_W-1:0] nxt_count;
  logic stop_ff;
  wire counting = state_ff == TS_COUNT;
  wire expire_now = counting && (count_ff == tif.limit);
  wire count_max = &count_ff;
  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // restart at frame
  assign nxt_count = tif.frame_start ? '0 :
                     (counting && !count_max) ? count_ff + 1'b1 :
                     count_ff;
  always_comb begin
    nxt_state = state_ff;
    if (tif.frame_start) begin
      nxt_state = TS_COUNT;
    end else begin
      case (state_ff)
        TS_IDLE: nxt_state = TS_IDLE;
        TS_COUNT: begin
          if (!tif.busy) nxt_state = TS_IDLE;
          else if (expire_now) nxt_state = TS_EXPIRED;
        end
        TS_EXPIRED: begin
          if (!tif.busy) nxt_state = TS_IDLE;
        end
        default: nxt_state = TS_IDLE;
      endcase
    end
  end
  wire stop_cause = (state_ff == TS_EXPIRED) && tif.gnt_n_sync;
  wire nxt_stop = !tif.frame_start && tif.busy && (stop_cause || stop_ff);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= TS_IDLE;
      count_ff <= '0;
      stop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      stop_ff <= nxt_stop;
    end
  end
  assign tif.expired = state_ff == TS_EXPIRED;
  assign tif.stop = stop_ff;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_COUNT_FROM_ZERO: assert property (
    @(posedge clk) disable iff (rst)
    tif.frame_start |=> (count_ff == '0) && (state_ff == TS_COUNT))
    else $error("tenure count did not restart at frame");
  AST_STOP_CAUSE: assert property (
    @(posedge clk) disable iff (rst)
    $rose(stop_ff) |-> $past(stop_cause))
    else $error("stop raised without expiry and lost grant");
  AST_STOP_PROMPT: assert property (
    @(posedge clk) disable iff (rst)
    (state_ff == TS_EXPIRED && tif.busy && tif.gnt_n_sync &&
     !tif.frame_start) |=> stop_ff)
    else $error("stop late after expiry and lost grant");
  COV_STOP: cover property (@(posedge clk) disable iff (rst)
    $rose(stop_ff));
endmodule : tenure_timer

/* host_side_model.sv */
`timescale 1ns/1ps
module host_side_model (
  input wire logic clk,
  input wire logic tenure_stop,
  output logic frame_start,
  output logic master_busy,
  output logic gnt_n
);
  // ------------------------------------------------------------
  // Master and arbiter lines
  // ------------------------------------------------------------
  initial begin
    frame_start = 1'b0;
    master_busy = 1'b0;
    gnt_n = 1'b1;
  end

  always @(negedge clk) begin
    if (master_busy && tenure_stop && !frame_start) begin
      master_busy = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Commands
  // ------------------------------------------------------------
  // frame starts tenure
  task automatic start_burst();
    @(negedge clk);
    frame_start = 1'b1;
    master_busy = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
  endtask : start_burst

  task automatic end_burst();
    @(negedge clk);
    master_busy = 1'b0;
  endtask : end_burst

  task automatic set_grant(input logic granted);
    @(negedge clk);
    gnt_n = ~granted;
  endtask : set_grant
endmodule : host_side_model

/* tb_pci_config_header_regs.sv */
`timescale 1ns/1ps
module tb_pci_config_header_regs;
  import cfg_hdr_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk, rst, cfg_valid, cfg_write, cfg_ack, window_hit;
  logic [5:0] cfg_dword;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr, rd;
  logic frame_start, master_busy, gnt_n, tenure_stop, tenure_expired;
  logic [LINE_W-1:0] line_length_setting;
  logic [WIN_W-1:0] window_upper_bits;
  logic [7:0] lims [3] = '{8'h00, 8'h02, 8'h05};
  int err_count = 0;
  int samples_checked = 0;
  int n;

  pci_config_header_regs u_dut (
    .clk(clk), .rst(rst), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_dword(cfg_dword), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .frame_start(frame_start),
    .master_busy(master_busy), .gnt_n(gnt_n), .tenure_stop(tenure_stop),
    .tenure_expired(tenure_expired),
    .line_length_setting(line_length_setting),
    .window_upper_bits(window_upper_bits), .mem_addr(mem_addr),
    .window_hit(window_hit)
  );

  host_side_model u_host (
    .clk(clk), .tenure_stop(tenure_stop), .frame_start(frame_start),
    .master_busy(master_busy), .gnt_n(gnt_n)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [5:0] dw,
      input logic [3:0] be, input logic [31:0] wd);
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_write = wr;
    cfg_dword = dw;
    cfg_be = be;
    cfg_wdata = wd;
    @(negedge clk);
    cfg_valid = 1'b0;
    chk({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
  endtask : xfer

  task automatic wr_rd(input logic [5:0] dw, input logic [31:0] wd);
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_write = 1'b1;
    cfg_dword = dw;
    cfg_be = 4'hf;
    cfg_wdata = wd;
    @(negedge clk);
    cfg_write = 1'b0;
    chk({31'h0, cfg_ack}, 32'h1);
    @(negedge clk);
    cfg_valid = 1'b0;
    chk({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
  endtask : wr_rd

  task automatic rchk(input logic [5:0] dw, input logic [31:0] exp);
    xfer(1'b0, dw, 4'hf, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic hit(input logic [31:0] a, input logic e);
    @(negedge clk);
    mem_addr = a;
    @(negedge clk);
    chk({31'h0, window_hit}, {31'h0, e});
  endtask : hit

  task automatic run_tenure(input logic [7:0] lim);
    xfer(1'b1, DW_TENURE_LINE, 4'h2, {16'h0, lim, 8'h0});
    u_host.start_burst();
    n = 1;
    while (tenure_stop !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask : run_tenure

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cfg_valid = 1'b0;
    cfg_write = 1'b0;
    cfg_dword = 6'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    mem_addr = 32'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rchk(DW_TENURE_LINE, 32'h0000_0000);
    rchk(DW_WINDOW, 32'h0000_0000);
    rchk(6'h05, 32'h0000_0000);
    xfer(1'b1, DW_TENURE_LINE, 4'hf, 32'ha5a5_3c12);
    chk({24'h0, line_length_setting}, 32'h0000_0012);
    rchk(DW_TENURE_LINE, 32'h0000_3c12);
    xfer(1'b1, DW_TENURE_LINE, 4'h2, 32'hffff_77ff);
    rchk(DW_TENURE_LINE, 32'h0000_7712);
    xfer(1'b1, DW_TENURE_LINE, 4'hc, 32'hffff_ffff);
    rchk(DW_TENURE_LINE, 32'h0000_7712);
    wr_rd(DW_WINDOW, 32'hffff_ffff);
    chk(rd, 32'hffff_f800);
    chk({11'h0, window_upper_bits}, 32'h001f_ffff);
    xfer(1'b1, DW_WINDOW, 4'hf, 32'h1234_5fff);
    rchk(DW_WINDOW, 32'h1234_5800);
    xfer(1'b1, DW_WINDOW, 4'h1, 32'hffff_ffff);
    rchk(DW_WINDOW, 32'h1234_5800);
    hit(32'h1234_5800, 1'b1);
    hit(32'h1234_5fff, 1'b1);
    hit(32'h1234_57ff, 1'b0);
    hit(32'h1234_6000, 1'b0);
    foreach (lims[i]) begin
      run_tenure(lims[i]);
      chk(32'(n), 32'(lims[i]) + 32'd3);
      chk({31'h0, tenure_expired}, 32'h1);
      repeat (3) @(negedge clk);
      chk({31'h0, tenure_stop}, 32'h0);
    end
    u_host.set_grant(1'b1);
    repeat (6) @(negedge clk);
    run_tenure(8'h02);
    chk({31'h0, tenure_stop}, 32'h0);
    chk({31'h0, tenure_expired}, 32'h1);
    u_host.set_grant(1'b0);
    n = 0;
    while (tenure_stop !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n >= 3 && n <= 6), 32'h1);
    xfer(1'b1, DW_TENURE_LINE, 4'h2, 32'h0000_1000);
    u_host.start_burst();
    u_host.end_burst();
    repeat (30) @(negedge clk);
    chk({31'h0, tenure_stop}, 32'h0);
    chk({31'h0, tenure_expired}, 32'h0);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk({24'h0, line_length_setting}, 32'h0000_0000);
    chk({11'h0, window_upper_bits}, 32'h0000_0000);
    rchk(DW_TENURE_LINE, 32'h0000_0000);
    test_done();
  end

  initial begin
    #(40 * 5000);
    err_count++;
    test_done();
  end
endmodule : tb_pci_config_header_regs
